// ===== recx_regs.sv
// extended power control / status register bank of the clock
// assumes the host multiplexed bus pins, the 32.768 kHz clock as a
// pin, update request and alarm match from the timekeeping core
`timescale 1ns/1ns
module recx_regs
   import recx_pkg::*;
#(
   parameter int UPD_LEAD = UPD_LEAD_CYC
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // host multiplexed bus
   input  wire logic [7:0] adIn,
   output logic      [7:0] adOut,
   output logic            adOe,
   input  wire logic       aleIn,
   input  wire logic       csInN,
   input  wire logic       wrInN,
   input  wire logic       rdInN,
   // event pins and core status
   input  wire logic       kickstartInN,
   input  wire logic       ramClearInN,
   input  wire logic       auxBatteryOk,
   input  wire logic       mainPowerOk,
   input  wire logic       khzClk,
   input  wire logic       updRequest,
   input  wire logic       wakeMatch,
   // open-drain outputs, low when enable high
   output logic            powerRequestOut,
   output logic            powerRequestOe,
   output logic            irqOutN,
   output logic            irqOe,
   // analog and ram side controls
   output logic            squareWaveOut,
   output logic            xtalLoadSel,
   output logic            auxBatteryEnable,
   output logic            burstAutoIncOn
);
   // ==========================================================
   // pin synchronisation
   logic [8:0] pinSync;
   recx_sync #(.W(9)) uSync (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .pinIn   ({~aleIn, csInN, wrInN, rdInN, kickstartInN,
                 ramClearInN, auxBatteryOk, mainPowerOk, khzClk}),
      .syncOut (pinSync)
   );
   // ale goes in inverted so the synchroniser's reset level matches
   // its idle low, otherwise reset would look like a strobe fall
   logic       aleLowS, csS, wrS, rdS, kickS, rclrS, auxS, pwrS, khzS;
   wire        aleS = ~aleLowS;
   assign {aleLowS, csS, wrS, rdS, kickS, rclrS, auxS, pwrS, khzS} =
          pinSync;
   // address bits are sampled two cycles after ale falls; the host keeps them
   // steady past the strobe fall
   logic [7:0] adS1_r, adS2_r, adS3_r;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         adS1_r <= RST_ADDR;
         adS2_r <= RST_ADDR;
         adS3_r <= RST_ADDR;
      end else begin
         adS1_r <= adIn;
         adS2_r <= adS1_r;
         adS3_r <= adS2_r;
      end
   end
   // ==========================================================
   // edge detection on filtered pins
   recx_bus_t prev_r;
   logic kickPrev_r, rclrPrev_r, pwrPrev_r;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prev_r     <= '{strobe: 1'b0, wr: 1'b1, rd: 1'b1, cs: 1'b1};
         kickPrev_r <= 1'b1;
         rclrPrev_r <= 1'b1;
         pwrPrev_r  <= 1'b1; // matches synced reset, no false power-up
      end else begin
         prev_r     <= '{strobe: aleS, wr: wrS, rd: rdS, cs: csS};
         kickPrev_r <= kickS;
         rclrPrev_r <= rclrS;
         pwrPrev_r  <= pwrS;
      end
   end
   wire aleFall  = prev_r.strobe & ~aleS;
   wire wrRise   = ~prev_r.wr & wrS & ~csS;
   wire rdFall   = prev_r.rd & ~rdS & ~csS;
   wire kickFall = kickPrev_r & ~kickS;
   wire rclrFall = rclrPrev_r & ~rclrS;
   wire pwrUp    = ~pwrPrev_r & pwrS;
   wire pwrDown  = pwrPrev_r & ~pwrS;
   // ==========================================================
   // address recovery stack, pushed on each strobe fall
   logic [7:0] stack_r [STACK_DEPTH];
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < STACK_DEPTH; i++) stack_r[i] <= RST_ADDR;
      end else if (aleFall) begin
         stack_r[0] <= adS3_r;
         for (int i = 1; i < STACK_DEPTH; i++) begin
            stack_r[i] <= stack_r[i-1];
         end
      end
   end
   wire [7:0] curAddr = stack_r[0];
   // ==========================================================
   // bank select lives in register 0x0A bit 4
   logic bankSel_r;
   wire  isBankCtl = (curAddr == OFS_BANK_CTRL);
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) bankSel_r <= 1'b0;
      else if (wrRise && isBankCtl) bankSel_r <= adIn[BIT_BANK_SEL];
   end
   // one decode shared by every bank one location
   function automatic logic bankHit(input logic       sel,
                                    input logic [7:0] addr,
                                    input logic [7:0] ofs);
      return sel && (addr == ofs);
   endfunction : bankHit
   // address decode, bank one only
   wire selStatus  = bankHit(bankSel_r, curAddr, OFS_EXT_STATUS);
   wire selFeature = bankHit(bankSel_r, curAddr, OFS_EXT_FEATURE);
   wire selStkLo   = bankHit(bankSel_r, curAddr, OFS_STACK_LOW);
   wire selStkHi   = bankHit(bankSel_r, curAddr, OFS_STACK_HIGH);
   wire wrStatus   = wrRise && selStatus;
   wire wrFeature  = wrRise && selFeature;
   // ==========================================================
   // feature control register
   logic [7:0] feature_r;
   // power-up set comes last so a write in the same cycle cannot
   // lose it
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         feature_r <= RST_FEATURE;
      end else begin
         if (wrFeature) feature_r <= adIn;
         if (pwrUp) feature_r[BIT_KHZ_EN] <= 1'b1;
      end
   end
   wire wakeEn = feature_r[BIT_WAKE_EN];
   wire kickEn = feature_r[BIT_KICK_EN];
   wire rclrEn = feature_r[BIT_RAM_CLEAR_IN_EN];
   // ==========================================================
   // ram clear sequencer: sweeps the user bytes writing ones
   recx_rc_state_t rcState_r;
   logic [6:0]     rcAddr_r;
   wire            rcStart = rclrEn && rclrFall;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rcState_r <= RC_IDLE;
         rcAddr_r  <= 7'h00;
      end else begin
         case (rcState_r)
            RC_IDLE: if (rcStart) begin
               rcState_r <= RC_CLEAR;
               rcAddr_r  <= 7'(USER_RAM_BASE);
            end
            RC_CLEAR: begin
               rcAddr_r <= rcAddr_r + 7'h01;
               if (rcAddr_r == 7'(USER_RAM_BASE + USER_RAM_BYTES - 1))
                  rcState_r <= RC_DONE;
            end
            RC_DONE:  rcState_r <= RC_IDLE;
            default:  rcState_r <= RC_IDLE;
         endcase
      end
   end
   wire rcDone = (rcState_r == RC_DONE);
   // user ram: only the clear sweep writes it here; clock and extended
   // storage sit elsewhere and are not touched
   logic [7:0] ramRd;
   recx_ram uRam (
      .clk_sys (clk_sys),
      .wrEn    (rcState_r == RC_CLEAR),
      .wrAddr  (rcAddr_r),
      .wrData  (8'hFF),
      .rdAddr  (curAddr[6:0]),
      .rdData  (ramRd)
   );
   // ==========================================================
   // update in progress: raised a lead time ahead of each update
   logic [$clog2(UPD_LEAD + UPD_BUSY_CYC + 1)-1:0] updCnt_r;
   logic updBusy_r;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         updCnt_r  <= '0;
         updBusy_r <= 1'b0;
      end else if (updRequest && !updBusy_r) begin
         updBusy_r <= 1'b1;
         updCnt_r  <= '0;
      end else if (updBusy_r) begin
         updCnt_r <= updCnt_r + 1'b1;
         if (updCnt_r == $bits(updCnt_r)'(UPD_LEAD + UPD_BUSY_CYC - 1))
            updBusy_r <= 1'b0;
      end
   end
   // ==========================================================
   // status flags; hardware set beats software clear
   logic wake_r, kick_r, rclrFlag_r, pwrInact_r, burst_r, rsvd_r;
   wire  wakeSet = wakeMatch;
   wire  kickSet = kickFall;
   wire  rcfSet  = rcDone;
   wire  wakeHit = wake_r & wakeEn;
   wire  kickHit = kick_r & kickEn;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wake_r     <= 1'b0;
         kick_r     <= 1'b0;
         rclrFlag_r <= 1'b0;
         pwrInact_r <= 1'b1;
         burst_r    <= 1'b0;
         rsvd_r     <= 1'b0;
      end else begin
         if (wakeSet) wake_r <= 1'b1;
         else if (wrStatus) wake_r <= adIn[BIT_WAKE_FLAG];
         if (kickSet) kick_r <= 1'b1;
         else if (wrStatus) kick_r <= adIn[BIT_KICK_FLAG];
         if (rcfSet) rclrFlag_r <= 1'b1;
         else if (wrStatus) rclrFlag_r <= adIn[BIT_RAM_CLEAR_IN_FLAG];
         if (wakeHit || kickHit) pwrInact_r <= 1'b0;
         else if (wrStatus) pwrInact_r <= adIn[BIT_PWR_INACT];
         if (wrStatus) begin
            burst_r <= adIn[BIT_BURST];
            rsvd_r  <= adIn[BIT_RSVD];
         end
      end
   end
   wire [7:0] statusVal = {auxS, updBusy_r, burst_r, rsvd_r,
                           pwrInact_r, rclrFlag_r, wake_r, kick_r};
   // ==========================================================
   // read data mux; unmapped locations fall through to user ram
   wire [7:0] rdMux = selStatus  ? statusVal :
                      selFeature ? feature_r :
   // 4E shows the address two pushes back, the one lost to an
   // interrupt once 0A and 4E have been latched on top of it
                      selStkLo   ? stack_r[2] :
                      selStkHi   ? stack_r[3] :
                      ramRd;
   // open-drain drive: interrupt only with main power present
   wire irqPend = pwrS && (wakeHit || kickHit ||
                  (rclrFlag_r && feature_r[BIT_RAM_CLEAR_IN_IEN]));
   // power request: held active unless inactive bit, or power fail
   // with release select clear
   logic pfRel_r;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) pfRel_r <= 1'b0;
      else if (pwrDown && !feature_r[BIT_PF_REL]) pfRel_r <= 1'b1;
      else if (wakeHit || kickHit || pwrUp) pfRel_r <= 1'b0;
   end
   wire pwrDrive = (!pwrInact_r && !pfRel_r) || wakeHit || kickHit;
   // ==========================================================
   // registered outputs
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         adOut            <= 8'h00;
         adOe             <= 1'b0;
         powerRequestOut  <= 1'b0;
         powerRequestOe   <= 1'b0;
         irqOutN          <= 1'b0;
         irqOe            <= 1'b0;
         squareWaveOut    <= 1'b0;
         xtalLoadSel      <= 1'b0;
         auxBatteryEnable <= 1'b0;
         burstAutoIncOn   <= 1'b0;
      end else begin
         if (rdFall) adOut <= rdMux;
         adOe             <= ~rdS & ~csS;
         powerRequestOe   <= pwrDrive;
         irqOe            <= irqPend;
         squareWaveOut    <= feature_r[BIT_KHZ_EN] & khzS;
         xtalLoadSel      <= feature_r[BIT_XTAL_SEL];
         auxBatteryEnable <= feature_r[BIT_AUX_EN];
         burstAutoIncOn   <= burst_r;
      end
   end
endmodule : recx_regs

// ===== recx_pkg.sv
// package for the extended power control register bank
// assumes an 8-bit multiplexed address/data host bus, one system clock
package recx_pkg;
   // ==========================================================
   // register locations, bank 1; the bank control at 0x0A is decoded in either bank
   localparam logic [7:0] OFS_EXT_STATUS   = 8'h4A;
   localparam logic [7:0] OFS_EXT_FEATURE  = 8'h4B;
   localparam logic [7:0] OFS_STACK_LOW    = 8'h4E;
   localparam logic [7:0] OFS_STACK_HIGH   = 8'h4F;
   localparam logic [7:0] OFS_BANK_CTRL    = 8'h0A;
   // ==========================================================
   // status register field positions
   localparam int BIT_AUX_VALID = 7;
   localparam int BIT_UPD_PROG  = 6;
   localparam int BIT_BURST     = 5;
   localparam int BIT_RSVD      = 4;
   localparam int BIT_PWR_INACT = 3;
   localparam int BIT_RAM_CLEAR_IN_FLAG = 2;
   localparam int BIT_WAKE_FLAG = 1;
   localparam int BIT_KICK_FLAG = 0;
   // feature register field positions
   localparam int BIT_AUX_EN    = 7;
   localparam int BIT_KHZ_EN    = 6;
   localparam int BIT_XTAL_SEL  = 5;
   localparam int BIT_RAM_CLEAR_IN_EN   = 4;
   localparam int BIT_PF_REL    = 3;
   localparam int BIT_RAM_CLEAR_IN_IEN  = 2;
   localparam int BIT_WAKE_EN   = 1;
   localparam int BIT_KICK_EN   = 0;
   // bank select bit position in register 0x0A
   localparam int BIT_BANK_SEL  = 4;
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_STATUS  = 8'h00;
   localparam logic [7:0] RST_FEATURE = 8'h40;
   localparam logic [7:0] RST_ADDR    = 8'h00;
   // ==========================================================
   // timing
   localparam int CLK_MHZ          = 50;
   localparam int UPD_LEAD_US      = 122;
   localparam int UPD_LEAD_CYC     = UPD_LEAD_US * CLK_MHZ;
   localparam int USER_RAM_BYTES   = 114;
   localparam int USER_RAM_BASE    = 14;
   localparam int STACK_DEPTH      = 4;
   localparam int UPD_BUSY_CYC     = 100;
   // ==========================================================
   // bus strobes after synchronisation
   typedef struct packed {
      logic       strobe;
      logic       wr;
      logic       rd;
      logic       cs;
   } recx_bus_t;
   typedef enum logic [1:0] {
      RC_IDLE  = 2'b00,
      RC_CLEAR = 2'b01,
      RC_DONE  = 2'b10
   } recx_rc_state_t;
endpackage : recx_pkg

// ===== recx_sync.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous pin inputs, one clock domain
`timescale 1ns/1ns
module recx_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   // pins and result
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   // value counts once stages two and three agree
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s1_r    <= '1;
         s2_r    <= '1;
         s3_r    <= '1;
         syncOut <= '1;
      end else begin
         s1_r <= pinIn;
         s2_r <= s1_r;
         s3_r <= s2_r;
         syncOut <= (s2_r & s3_r) | (syncOut & (s2_r ^ s3_r));
      end
   end
endmodule : recx_sync

// ===== recx_ram.sv
// user ram, 114 bytes plus room, one write port, registered read
// clear sweeps one byte a cycle driven by the owner
`timescale 1ns/1ns
module recx_ram #(
   parameter int DEPTH = 128,
   parameter int AW    = 7
) (
   // clock
   input  wire logic          clk_sys,
   // write port
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [7:0]    wrData,
   // read port
   input  wire logic [AW-1:0] rdAddr,
   output logic      [7:0]    rdData
);
   logic [7:0] mem [DEPTH];
   // registered read keeps the read path short
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule : recx_ram

// ===== recx_regs_props.sv
// checker of the extended power control bank, pin relations only
// assumes it is bound to recx_regs, one clock, async active high reset
`timescale 1ns/1ns
module recx_regs_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // bus strobes
   input wire logic adOe,
   input wire logic csInN,
   input wire logic wrInN,
   input wire logic rdInN,
   // levels and outputs
   input wire logic mainPowerOk,
   input wire logic khzClk,
   input wire logic powerRequestOut,
   input wire logic powerRequestOe,
   input wire logic irqOutN,
   input wire logic irqOe,
   input wire logic squareWaveOut
);
   // ==========================================================
   // cycles since a write strobe or a power loss; outputs may
   // only be released shortly after one of those causes
   logic [4:0] quiet_r;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) quiet_r <= 5'h1F;
      else if (!mainPowerOk || !wrInN) quiet_r <= 5'h00;
      else if (quiet_r != 5'h1F) quiet_r <= quiet_r + 5'h01;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // open-drain pins and bus turnaround
   a_pwr_pin_low: assert property (powerRequestOe |-> !powerRequestOut)
      else $error("power request driven high");
   a_irq_pin_low: assert property (irqOe |-> !irqOutN)
      else $error("interrupt driven high");
   a_irq_needs_power: assert property (!mainPowerOk [*8] |-> !irqOe)
      else $error("interrupt driven without main power");
   a_bus_released: assert property ((rdInN || csInN) [*8] |-> !adOe)
      else $error("bus driven outside a read");
   a_bus_on_read: assert property ($rose(adOe) |-> !rdInN && !csInN)
      else $error("bus drive began without a read");
   a_sqw_quiet: assert property (!khzClk [*8] |-> !squareWaveOut)
      else $error("square wave high while oscillator low");
   a_pwr_fall_cause: assert property (
      $fell(powerRequestOe) |-> quiet_r < 5'd12)
      else $error("power request released without cause");
   a_irq_fall_cause: assert property (
      $fell(irqOe) |-> quiet_r < 5'd12)
      else $error("interrupt released without cause");
endmodule : recx_regs_props

bind recx_regs recx_regs_props u_props (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .adOe(adOe), .csInN(csInN), .wrInN(wrInN),
   .rdInN(rdInN), .mainPowerOk(mainPowerOk), .khzClk(khzClk),
   .powerRequestOut(powerRequestOut), .powerRequestOe(powerRequestOe),
   .irqOutN(irqOutN), .irqOe(irqOe), .squareWaveOut(squareWaveOut));

// ===== recx_host.sv
// host processor model on the multiplexed address/data bus
// assumes the recx_regs bus pins and the system clock
`timescale 1ns/1ns
module recx_host
   import recx_pkg::*;
(
   // clock
   input  wire logic       clk_sys,
   // device side of the bus
   input  wire logic [7:0] adOut,
   input  wire logic       adOe,
   // host strobes and bus
   output logic      [7:0] adIn,
   output logic            aleIn,
   output logic            csInN,
   output logic            wrInN,
   output logic            rdInN
);
   logic       drv;
   logic [7:0] drvVal, lastVal;
   // ==========================================================
   // a released bus flips every cycle so no stale byte passes
   assign adIn = adOe ? adOut : (drv ? drvVal : ~lastVal);
   always @(posedge clk_sys) lastVal <= adIn;
   initial begin
      drv = 1'b0; drvVal = 8'h00; lastVal = 8'h00;
      aleIn = 1'b0; csInN = 1'b1; wrInN = 1'b1; rdInN = 1'b1;
   end
   // ==========================================================
   // bus cycles, every phase held six cycles for the synchroniser, the read strobe ten
   task automatic phase(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : phase
   task automatic latch(input logic [7:0] a);
      drv <= 1'b1; drvVal <= a; aleIn <= 1'b1; phase(6);
      aleIn <= 1'b0; phase(6);
   endtask : latch
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      latch(a);
      csInN <= 1'b0; drvVal <= d; phase(6);
      wrInN <= 1'b0; phase(6);
      wrInN <= 1'b1; phase(6); // data held past the rising strobe
      csInN <= 1'b1; drv <= 1'b0; phase(6);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      latch(a);
      drv <= 1'b0; csInN <= 1'b0; rdInN <= 1'b0; phase(10);
      d = adOut;
      rdInN <= 1'b1; csInN <= 1'b1; phase(6);
   endtask : rd_reg
   // bank bit must be set before the extended registers are seen
   task automatic sel_bank(input logic on);
      wr_reg(OFS_BANK_CTRL, {3'h0, on, 4'h0});
   endtask : sel_bank
endmodule : recx_host

// ===== recx_regs_test.sv
// testbench of the extended power control register bank
// assumes recx_regs, recx_host and the bound checker are compiled
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin numErrors++; \
   $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
module recx_regs_test
   import recx_pkg::*;
();
   logic       clk_sys, sys_rst, adOe, aleIn, csInN, wrInN, rdInN;
   logic [7:0] adIn, adOut, d, flg;
   logic       kickstartInN, ramClearInN, auxBatteryOk, mainPowerOk;
   logic       khzClk, updRequest, wakeMatch, powerRequestOut;
   logic       powerRequestOe, irqOutN, irqOe, squareWaveOut;
   logic       xtalLoadSel, auxBatteryEnable, burstAutoIncOn;
   logic [5:0] khzCnt;
   int         numErrors, checks, i;
   // ==========================================================
   // design, host and slow oscillator stand-in
   recx_regs #(.UPD_LEAD(10)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .adIn(adIn), .adOut(adOut), .adOe(adOe), .aleIn(aleIn),
      .csInN(csInN), .wrInN(wrInN), .rdInN(rdInN),
      .kickstartInN(kickstartInN), .ramClearInN(ramClearInN),
      .auxBatteryOk(auxBatteryOk), .mainPowerOk(mainPowerOk),
      .khzClk(khzClk), .updRequest(updRequest), .wakeMatch(wakeMatch),
      .powerRequestOut(powerRequestOut), .powerRequestOe(powerRequestOe),
      .irqOutN(irqOutN), .irqOe(irqOe), .squareWaveOut(squareWaveOut),
      .xtalLoadSel(xtalLoadSel), .auxBatteryEnable(auxBatteryEnable),
      .burstAutoIncOn(burstAutoIncOn));
   recx_host host (.clk_sys(clk_sys), .adOut(adOut), .adOe(adOe),
      .adIn(adIn), .aleIn(aleIn), .csInN(csInN), .wrInN(wrInN),
      .rdInN(rdInN));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      khzCnt <= khzCnt + 6'h01;
      khzClk <= khzCnt[4];
   end
   // ==========================================================
   // helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   task automatic fire(input int k); // 0 wake 1 kick 2 clear 3 update
      wakeMatch    <= (k == 0);
      kickstartInN <= (k != 1);
      ramClearInN  <= (k != 2);
      updRequest   <= (k == 3);
      tick(1);
      wakeMatch <= 1'b0; updRequest <= 1'b0; tick(8);
      kickstartInN <= 1'b1; ramClearInN <= 1'b1; tick(12);
   endtask : fire
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", numErrors, checks);
      if (numErrors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   initial begin
      tick(90000);
      numErrors++;
      wrap_up();
   end
   // ==========================================================
   // main sequence
   initial begin
      sys_rst = 1'b1; kickstartInN = 1'b1; ramClearInN = 1'b1;
      auxBatteryOk = 1'b1; mainPowerOk = 1'b1; khzClk = 1'b0;
      khzCnt = 6'h00; updRequest = 1'b0; wakeMatch = 1'b0;
      numErrors = 0; checks = 0;
      tick(3); sys_rst <= 1'b0; tick(8);
      host.sel_bank(1'b1);
      host.rd_reg(OFS_EXT_FEATURE, d); `CHK(d, RST_FEATURE)
      host.rd_reg(OFS_EXT_STATUS, d); `CHK(d, 8'h88)
      for (i = 0; i < 80 && squareWaveOut !== 1'b1; i++) tick(1);
      `CHK(squareWaveOut, 1'b1)
      if (squareWaveOut !== 1'b1) wrap_up();
      auxBatteryOk <= 1'b0; tick(8);
      host.rd_reg(OFS_EXT_STATUS, d); `CHK(d, 8'h08)
      auxBatteryOk <= 1'b1;
      host.wr_reg(OFS_EXT_FEATURE, 8'hB4); tick(40);
      `CHK(squareWaveOut, 1'b0)
      `CHK({auxBatteryEnable, xtalLoadSel}, 2'b11)
      host.wr_reg(OFS_EXT_STATUS, 8'h30);
      `CHK({powerRequestOe, burstAutoIncOn}, 2'b11)
      host.rd_reg(OFS_EXT_STATUS, d); `CHK(d, 8'hB0)
      host.wr_reg(OFS_EXT_STATUS, 8'h08);
      `CHK({powerRequestOe, burstAutoIncOn}, 2'b00)
      // wake then kick, each with its enable off and on
      for (int k = 0; k < 2; k++) begin
         for (int en = 0; en < 2; en++) begin
            flg = 8'h01 << (1 - k);
            host.wr_reg(OFS_EXT_FEATURE, 8'hB4 | (en[0] ? flg : 8'h00));
            fire(k);
            `CHK({powerRequestOe, irqOe}, {2{en[0]}})
            host.rd_reg(OFS_EXT_STATUS, d);
            `CHK(d, (en[0] ? 8'h80 : 8'h88) | flg)
            // the first write lands while the enabled flag still clears
            // the inactive bit, so a second one releases power request
            host.wr_reg(OFS_EXT_STATUS, 8'h08);
            `CHK(irqOe, 1'b0)
            host.wr_reg(OFS_EXT_STATUS, 8'h08);
            `CHK(powerRequestOe, 1'b0)
         end
      end
      // power fail release follows the select bit
      host.wr_reg(OFS_EXT_FEATURE, 8'hB4);
      host.wr_reg(OFS_EXT_STATUS, 8'h00);
      mainPowerOk <= 1'b0; tick(12);
      `CHK(powerRequestOe, 1'b0)
      // wake while unpowered: power request first, interrupt on return
      host.wr_reg(OFS_EXT_FEATURE, 8'hB6);
      fire(0);
      `CHK({powerRequestOe, irqOe}, 2'b10)
      mainPowerOk <= 1'b1; tick(12);
      `CHK(irqOe, 1'b1)
      host.wr_reg(OFS_EXT_FEATURE, 8'hBC);
      host.wr_reg(OFS_EXT_STATUS, 8'h00);
      mainPowerOk <= 1'b0; tick(12);
      `CHK(powerRequestOe, 1'b1)
      mainPowerOk <= 1'b1; tick(12);
      host.wr_reg(OFS_EXT_STATUS, 8'h08);
      // ram clear ignored when disabled, then done with interrupt
      host.sel_bank(1'b0);
      host.wr_reg(8'h20, 8'h5A);
      host.sel_bank(1'b1);
      host.wr_reg(OFS_EXT_FEATURE, 8'hA4);
      fire(2);
      host.rd_reg(OFS_EXT_STATUS, d); `CHK(d, 8'h88)
      host.wr_reg(OFS_EXT_FEATURE, 8'hB4);
      fire(2);
      `CHK(irqOe, 1'b0)
      for (i = 0; i < 300 && irqOe !== 1'b1; i++) tick(1);
      `CHK(irqOe, 1'b1)
      if (irqOe !== 1'b1) wrap_up();
      host.rd_reg(OFS_EXT_STATUS, d); `CHK(d, 8'h8C)
      host.wr_reg(OFS_EXT_STATUS, 8'h08); `CHK(irqOe, 1'b0)
      host.sel_bank(1'b0);
      host.rd_reg(8'h20, d); `CHK(d, 8'hFF)
      // lost address two pushes back, bank write in between
      host.sel_bank(1'b1);
      host.rd_reg(OFS_STACK_LOW, d); `CHK(d, 8'h20)
      host.rd_reg(OFS_STACK_HIGH, d); `CHK(d, 8'h20)
      // update flag leads the update and then drops
      fire(3);
      host.rd_reg(OFS_EXT_STATUS, d); `CHK(d, 8'hC8)
      tick(150);
      host.rd_reg(OFS_EXT_STATUS, d); `CHK(d, 8'h88)
      wrap_up();
   end
endmodule : recx_regs_test
